// File: rtl/flash_cmd_pkg.sv
// Constants, field layouts and carrier types for the flash command and configuration block.
// Assumes a 100 MHz clock, synchronous active-high reset and an AXI4-Lite register bus.
// Overview of operation
// [R1] Host clears complete flag before each command
// [R2] Complete flag returns ready when operation ends
// [R3] Code 0000h loads main sectors into buffer
// [R4] Code 0013h loads spare sectors into buffer
// [R5] 0080h programs main+spare, 001Ah spare only
// [R6] Host fills read-only spare bytes with FF
// [R7] Code 001Bh performs copy back program
// [R8] Unlock, lock, lock-tight refused while busy
// [R9] Busy long operations accept only reset codes
// [R10] 00F0h resets core, 00F3h hot reset
// [R11] Hot reset restores all registers, like warm; the code keeps the output enable bit through it
// [R12] Configuration resets to 40C0h
// [R13] Bit 15 selects async or sync reads
// [R14] Bits 14:12 set burst latency 3 to 7
// [R15] Bits 11:9 set burst length
// [R16] Bit 8 bypasses error correction
// [R17] Bit 7 sets valid pin polarity
// [R18] Bit 6 sets complete pin polarity
// [R19] Pins high-impedance until output enable set
// [R20] Output enable cleared by cold reset/write zero
// [R21] Bit 4 selects valid timing to data
// [R22] Bit 0 reads zero, boot buffer protected
// [R23] Failures and invalid commands set error bit
// [R24] Reserved bits 3:1 ignore writes, read zero
package flash_cmd_pkg;
  localparam logic [15:0] off_command_idx = 16'hF220;
  localparam logic [15:0] off_config_one_idx = 16'hF221;
  localparam logic [15:0] off_config_two_idx = 16'hF222;
  localparam logic [15:0] off_status_idx = 16'hF240;
  localparam logic [15:0] off_complete_idx = 16'hF241;
  localparam logic [15:0] command_reset = 16'h0000;
  localparam logic [15:0] config_reset = 16'h40C0;
  localparam logic [15:0] config_write_mask = 16'hFFF0;
  localparam int read_mode_bit = 15;
  localparam int latency_lsb = 12;
  localparam int length_lsb = 9;
  localparam int ecc_bypass_bit = 8;
  localparam int valid_pol_bit = 7;
  localparam int complete_pol_bit = 6;
  localparam int output_enable_bit = 5;
  localparam int valid_timing_bit = 4;
  localparam logic [2:0] latency_min_code = 3'h3;
  localparam logic [2:0] latency_default = 3'h4;
  localparam logic [2:0] length_max_code = 3'h4;
  localparam logic [15:0] cmd_load_main = 16'h0000;
  localparam logic [15:0] cmd_load_spare = 16'h0013;
  localparam logic [15:0] cmd_prog_main = 16'h0080;
  localparam logic [15:0] cmd_prog_spare = 16'h001A;
  localparam logic [15:0] cmd_copy_back = 16'h001B;
  localparam logic [15:0] cmd_unlock = 16'h0023;
  localparam logic [15:0] cmd_lock = 16'h002A;
  localparam logic [15:0] cmd_lock_tight = 16'h002C;
  localparam logic [15:0] cmd_erase_verify = 16'h0071;
  localparam logic [15:0] cmd_block_erase = 16'h0094;
  localparam logic [15:0] cmd_multi_erase = 16'h0095;
  localparam logic [15:0] cmd_erase_suspend = 16'h00B0;
  localparam logic [15:0] cmd_erase_resume = 16'h0030;
  localparam logic [15:0] cmd_core_reset = 16'h00F0;
  localparam logic [15:0] cmd_hot_reset = 16'h00F3;
  localparam logic [15:0] cmd_otp_access = 16'h0065;
  localparam int status_busy_bit = 15;
  localparam int status_error_bit = 10;
  localparam int status_suspend_bit = 9;
  localparam int status_reset_bit = 7;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  typedef enum logic [3:0] {
    op_none = 4'h0, op_load = 4'h1, op_program = 4'h2, op_copy = 4'h3,
    op_lock = 4'h4, op_erase = 4'h5, op_verify = 4'h6, op_suspend = 4'h7,
    op_resume = 4'h8, op_core_reset = 4'h9, op_hot_reset = 4'hA, op_otp = 4'hB
  } op_type;

  typedef struct packed {
    logic start;
    op_type op;
    logic spare_only;
    logic both_areas;
  } array_request_type;

  typedef struct packed {
    logic read_mode_select;
    logic [2:0] burst_latency;
    logic [2:0] burst_length;
    logic ecc_bypass;
    logic valid_pin_polarity;
    logic complete_pin_polarity;
    logic status_output_enable;
    logic valid_with_data;
  } config_fields_type;

  function automatic config_fields_type unpack_config(input logic [15:0] value);
    config_fields_type f;
    f.read_mode_select = value[read_mode_bit];
    f.burst_latency = value[latency_lsb +: 3];
    f.burst_length = value[length_lsb +: 3];
    f.ecc_bypass = value[ecc_bypass_bit];
    f.valid_pin_polarity = value[valid_pol_bit];
    f.complete_pin_polarity = value[complete_pol_bit];
    f.status_output_enable = value[output_enable_bit];
    f.valid_with_data = value[valid_timing_bit];
    return f;
  endfunction : unpack_config
endpackage : flash_cmd_pkg

// File: rtl/cmd_decoder.sv
// Combinational decoder from a command code to an array operation class.
// Assumes the caller gates acceptance against the busy state.
`timescale 1ns/1ps
module cmd_decoder (
  input wire logic [15:0] code,
  output flash_cmd_pkg::op_type op,
  output logic valid,
  output logic spare_only,
  output logic both_areas,
  output logic reset_code
);
  always_comb
  begin
    op = flash_cmd_pkg::op_none;
    valid = 1'b1;
    spare_only = 1'b0;
    both_areas = 1'b0;
    reset_code = 1'b0;
    unique case (code)
      flash_cmd_pkg::cmd_load_main: op = flash_cmd_pkg::op_load; // [R3]
      flash_cmd_pkg::cmd_load_spare:
      begin
        op = flash_cmd_pkg::op_load; // [R4]
        spare_only = 1'b1;
      end
      flash_cmd_pkg::cmd_prog_main:
      begin
        op = flash_cmd_pkg::op_program; // [R5]
        both_areas = 1'b1;
      end
      flash_cmd_pkg::cmd_prog_spare:
      begin
        op = flash_cmd_pkg::op_program; // [R5]
        spare_only = 1'b1;
      end
      flash_cmd_pkg::cmd_copy_back: op = flash_cmd_pkg::op_copy; // [R7]
      flash_cmd_pkg::cmd_unlock,
      flash_cmd_pkg::cmd_lock,
      flash_cmd_pkg::cmd_lock_tight: op = flash_cmd_pkg::op_lock; // [R8]
      flash_cmd_pkg::cmd_erase_verify: op = flash_cmd_pkg::op_verify;
      flash_cmd_pkg::cmd_block_erase,
      flash_cmd_pkg::cmd_multi_erase: op = flash_cmd_pkg::op_erase;
      flash_cmd_pkg::cmd_erase_suspend: op = flash_cmd_pkg::op_suspend;
      flash_cmd_pkg::cmd_erase_resume: op = flash_cmd_pkg::op_resume;
      flash_cmd_pkg::cmd_otp_access: op = flash_cmd_pkg::op_otp;
      flash_cmd_pkg::cmd_core_reset:
      begin
        op = flash_cmd_pkg::op_core_reset; // [R10]
        reset_code = 1'b1;
      end
      flash_cmd_pkg::cmd_hot_reset:
      begin
        op = flash_cmd_pkg::op_hot_reset; // [R10]
        reset_code = 1'b1;
      end
      default: valid = 1'b0;
    endcase
  end
endmodule : cmd_decoder

// File: rtl/flash_command_and_sysconfig.sv
// Command register, system configuration register and completion tracking, reached over AXI4-Lite.
// Assumes the array sequencer answers each started operation with a done pulse and a pass/fail level.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module flash_command_and_sysconfig (
  input wire logic clk,
  input wire logic srst,
  input wire logic cold_reset,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic array_done,
  input wire logic array_fail,
  output flash_cmd_pkg::array_request_type array_request,
  output logic [15:0] array_command,
  output flash_cmd_pkg::config_fields_type config_fields,
  output logic complete_pin_out,
  output logic complete_pin_oe_n,
  output logic valid_pin_ready_level,
  output logic valid_pin_oe_n
);
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_busy = 3'b010,
    st_resetting = 3'b100
  } op_state_type;

  function automatic logic addr_hit(input logic [17:0] addr, input logic [15:0] index);
    return addr[17:2] == index && addr[1:0] == 2'h0;
  endfunction : addr_hit

  // Bus write and read side
  logic aw_held_reg, aw_held_next;
  logic [17:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Block state
  logic [15:0] command_reg, command_next;
  logic [15:0] config_reg, config_next;
  logic complete_reg, complete_next;
  logic error_reg, error_next;
  logic suspend_reg, suspend_next;
  op_state_type state_reg, state_next;
  flash_cmd_pkg::array_request_type request_reg, request_next;
  logic complete_pin_reg, complete_pin_next;
  logic complete_oe_n_reg, complete_oe_n_next;
  logic valid_level_reg, valid_level_next;
  logic valid_oe_n_reg, valid_oe_n_next;

  logic wr_fire;
  logic wr_ok;
  logic [15:0] wr_val;
  logic [15:0] wr_mask;
  logic cmd_write;
  logic cfg_write;
  logic complete_write;
  flash_cmd_pkg::op_type dec_op;
  logic dec_valid;
  logic dec_spare;
  logic dec_both;
  logic dec_reset;
  logic [15:0] status_word;
  logic [15:0] cfg_written;

  cmd_decoder decoder (
    .code(wr_val),
    .op(dec_op),
    .valid(dec_valid),
    .spare_only(dec_spare),
    .both_areas(dec_both),
    .reset_code(dec_reset)
  );

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_val = w_data_reg[15:0];
  assign wr_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign cmd_write = wr_fire && addr_hit(aw_addr_reg, flash_cmd_pkg::off_command_idx);
  assign cfg_write = wr_fire && addr_hit(aw_addr_reg, flash_cmd_pkg::off_config_one_idx);
  assign complete_write = wr_fire && addr_hit(aw_addr_reg, flash_cmd_pkg::off_complete_idx);
  assign wr_ok = cmd_write || cfg_write || complete_write
    || (wr_fire && addr_hit(aw_addr_reg, flash_cmd_pkg::off_config_two_idx));
  // Bits 3:0 are never stored, so reserved bits and the protect bit read zero
  assign cfg_written = ((config_reg & ~wr_mask) | (wr_val & wr_mask)) & flash_cmd_pkg::config_write_mask; // [R22] [R24]

  always_comb
  begin
    status_word = 16'h0000;
    status_word[flash_cmd_pkg::status_busy_bit] = state_reg != st_idle;
    status_word[flash_cmd_pkg::status_error_bit] = error_reg; // [R23]
    status_word[flash_cmd_pkg::status_suspend_bit] = suspend_reg;
    status_word[flash_cmd_pkg::status_reset_bit] = state_reg == st_resetting;
  end

  always_comb
  begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_held_reg)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg)
    begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? flash_cmd_pkg::axi_okay : flash_cmd_pkg::axi_slverr;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
    end
    if (s_axi_arvalid && !arready_reg && !rvalid_reg)
    begin
      arready_next = 1'b1;
      rvalid_next = 1'b1;
      rresp_next = flash_cmd_pkg::axi_okay;
      if (addr_hit(s_axi_araddr, flash_cmd_pkg::off_command_idx))
        rdata_next = {16'h0000, command_reg};
      else if (addr_hit(s_axi_araddr, flash_cmd_pkg::off_config_one_idx))
        rdata_next = {16'h0000, config_reg};
      else if (addr_hit(s_axi_araddr, flash_cmd_pkg::off_config_two_idx))
        rdata_next = 32'h0000_0000;
      else if (addr_hit(s_axi_araddr, flash_cmd_pkg::off_status_idx))
        rdata_next = {16'h0000, status_word};
      else if (addr_hit(s_axi_araddr, flash_cmd_pkg::off_complete_idx))
        rdata_next = {31'h0000_0000, complete_reg};
      else
      begin
        rdata_next = 32'h0000_0000;
        rresp_next = flash_cmd_pkg::axi_slverr;
      end
    end
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    // Readies leave a flop so no gate sits between state and the bus
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
  end

  always_comb
  begin
    command_next = command_reg;
    config_next = config_reg;
    complete_next = complete_reg;
    error_next = error_reg;
    suspend_next = suspend_reg;
    state_next = state_reg;
    request_next = '0;
    if (complete_write && w_strb_reg[0])
      complete_next = wr_val[0];
    if (cfg_write)
      config_next = cfg_written;
    // A command write outranks a done pulse arriving in the same cycle
    if (cmd_write)
    begin
      command_next = (command_reg & ~wr_mask) | (wr_val & wr_mask);
      if (!dec_valid)
        error_next = 1'b1; // [R23]
      else if (state_reg != st_idle && !dec_reset)
        error_next = 1'b1; // [R8] [R9]
      else if (dec_op == flash_cmd_pkg::op_hot_reset)
      begin
        // Like a warm reset except output enable survives; cold reset, srst and a config write are what clear it
        command_next = flash_cmd_pkg::command_reset; // [R11]
        config_next = flash_cmd_pkg::config_reset | (config_reg & (16'h0001 << flash_cmd_pkg::output_enable_bit));
        error_next = 1'b0;
        suspend_next = 1'b0;
        complete_next = 1'b1;
        state_next = st_idle;
        request_next.start = 1'b1;
        request_next.op = dec_op;
      end
      else
      begin
        request_next.start = 1'b1; // [R3] [R4] [R5] [R7]
        request_next.op = dec_op;
        request_next.spare_only = dec_spare;
        request_next.both_areas = dec_both;
        error_next = 1'b0;
        complete_next = 1'b0;
        if (dec_op == flash_cmd_pkg::op_suspend)
          suspend_next = 1'b1;
        if (dec_op == flash_cmd_pkg::op_resume)
          suspend_next = 1'b0;
        state_next = dec_reset ? st_resetting : st_busy; // [R10]
      end
    end
    else if (state_reg != st_idle && array_done)
    begin
      state_next = st_idle;
      complete_next = 1'b1; // [R2]
      if (array_fail)
        error_next = 1'b1; // [R23]
    end
    if (cold_reset)
      config_next[flash_cmd_pkg::output_enable_bit] = 1'b0; // [R20]
  end

  always_comb
  begin
    // High level on the pin means ready when polarity bit is one
    complete_pin_next = complete_reg ~^ config_reg[flash_cmd_pkg::complete_pol_bit]; // [R18]
    valid_level_next = config_reg[flash_cmd_pkg::valid_pol_bit]; // [R17]
    complete_oe_n_next = !config_reg[flash_cmd_pkg::output_enable_bit]; // [R19]
    valid_oe_n_next = !config_reg[flash_cmd_pkg::output_enable_bit]; // [R19]
  end

  // Bus handshake state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= flash_cmd_pkg::axi_okay;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= flash_cmd_pkg::axi_okay;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Command, configuration and completion state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      command_reg <= flash_cmd_pkg::command_reset;
      config_reg <= flash_cmd_pkg::config_reset; // [R12]
      complete_reg <= 1'b1;
      error_reg <= 1'b0;
      suspend_reg <= 1'b0;
      state_reg <= st_idle;
      request_reg <= '0;
    end
    else
    begin
      command_reg <= command_next;
      config_reg <= config_next;
      complete_reg <= complete_next;
      error_reg <= error_next;
      suspend_reg <= suspend_next;
      state_reg <= state_next;
      request_reg <= request_next;
    end
  end

  // Pin drivers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      complete_pin_reg <= 1'b1;
      complete_oe_n_reg <= 1'b1;
      valid_level_reg <= 1'b1;
      valid_oe_n_reg <= 1'b1;
    end
    else
    begin
      complete_pin_reg <= complete_pin_next;
      complete_oe_n_reg <= complete_oe_n_next;
      valid_level_reg <= valid_level_next;
      valid_oe_n_reg <= valid_oe_n_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign array_request = request_reg;
  assign array_command = command_reg;
  // Latency, length, read mode, bypass and valid timing steer the read path outside
  assign config_fields = flash_cmd_pkg::unpack_config(config_reg); // [R13] [R14] [R15] [R16] [R21]
  assign complete_pin_out = complete_pin_reg;
  assign complete_pin_oe_n = complete_oe_n_reg;
  assign valid_pin_ready_level = valid_level_reg;
  assign valid_pin_oe_n = valid_oe_n_reg;
endmodule : flash_command_and_sysconfig

// File: bench/flash_command_and_sysconfig_monitor.sv
// Concurrent checks on the register bus and the pin outputs of the command block.
// Assumes it is bound into the top module and sees that module's ports unchanged.
`timescale 1ns/1ps
module flash_command_and_sysconfig_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire flash_cmd_pkg::array_request_type array_request,
  input wire flash_cmd_pkg::config_fields_type config_fields,
  input wire logic complete_pin_oe_n,
  input wire logic valid_pin_oe_n,
  input wire logic valid_pin_ready_level
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_asked;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  a_valid_oe_follow: assert property (valid_pin_oe_n == !$past(config_fields.status_output_enable))
    else $error("valid pin enable does not follow config");
  a_cmpl_oe_follow: assert property (complete_pin_oe_n == !$past(config_fields.status_output_enable))
    else $error("complete pin enable does not follow config");
  a_ready_level: assert property (valid_pin_ready_level == $past(config_fields.valid_pin_polarity))
    else $error("valid pin level does not follow polarity");
  a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_held_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (rd_asked |=> s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready)
    else $error("read response not released");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_start_pulse: assert property (array_request.start |=> !array_request.start)
    else $error("start longer than one cycle");
endmodule : flash_command_and_sysconfig_monitor
bind flash_command_and_sysconfig flash_command_and_sysconfig_monitor mon (.*);

// File: bench/array_model.sv
// Behavioural array sequencer: answers each started operation with a done pulse, unless a later start restarts the count first.
// Assumes the bench sets the answer delay and whether the next answer is a failure.
`timescale 1ns/1ps
module array_model (
  input wire logic clk,
  input wire logic srst,
  input wire flash_cmd_pkg::array_request_type array_request,
  input wire logic [7:0] delay,
  input wire logic fail_next,
  output logic array_done,
  output logic array_fail
);
  logic [7:0] count_reg;
  logic fail_reg;
  // A new start restarts the count, as a core reset cuts a running operation short
  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= 8'h00;
    else if (array_request.start)
      count_reg <= delay;
    else if (count_reg != 8'h00)
      count_reg <= count_reg - 8'h01;
    fail_reg <= fail_next;
  end
  assign array_done = (count_reg == 8'h01);
  // Outside the done pulse the fail level carries no meaning, so it shows the opposite value
  assign array_fail = array_done ? fail_reg : ~fail_reg;
endmodule : array_model

// File: bench/tb_flash_command_and_sysconfig.sv
// Self-checking bench for the command and configuration block.
// Assumes the array model answers starts; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
module tb_flash_command_and_sysconfig;
  localparam logic [17:0] a_cmd = 18'h3C880;
  localparam logic [17:0] a_cfg = 18'h3C884;
  localparam logic [17:0] a_stat = 18'h3C900;
  localparam logic [17:0] a_cmpl = 18'h3C904;
  logic clk, srst, cold_reset, fail_next, array_done, array_fail;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] array_command;
  logic complete_pin_out, complete_pin_oe_n, valid_pin_ready_level, valid_pin_oe_n;
  logic [7:0] delay;
  flash_cmd_pkg::array_request_type array_request, last_req;
  flash_cmd_pkg::config_fields_type config_fields;
  int miscompares, check_count, cycles, starts;
  flash_command_and_sysconfig uut (.*);
  array_model far_end (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (array_request.start === 1'b1)
    begin
      starts++;
      last_req = array_request;
    end
    if (cycles == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [17:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(rd, exp);
  endtask : rd_chk
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      rd_reg(a_cmpl);
      n++;
    end while (rd[0] !== 1'b1 && n < 40);
    check(rd[0], 1'b1);
  endtask : wait_ready
  task automatic run_cmd(input logic [15:0] code);
    wr(a_cmpl, 16'h0000);
    wr(a_cmd, code);
    wait_ready();
  endtask : run_cmd
  task automatic t_reset;
    rd_chk(a_cfg, 32'h40C0);
    rd_chk(a_cmd, 32'h0000);
    rd_chk(18'h3C888, 32'h0000);
    check({complete_pin_oe_n, valid_pin_oe_n}, 2'b11);
    check({config_fields.read_mode_select, config_fields.burst_latency, config_fields.burst_length,
      config_fields.ecc_bypass}, 8'h40);
    wr(18'h3C88C, 16'h1234);
    check(resp, flash_cmd_pkg::axi_slverr);
    rd_chk(18'h3C88C, 32'h0000);
    check(resp, flash_cmd_pkg::axi_slverr);
  endtask : t_reset
  task automatic t_config;
    wr(a_cfg, 16'hFFFF);
    rd_chk(a_cfg, 32'hFFF0);
    check({config_fields.read_mode_select, config_fields.ecc_bypass}, 2'b11);
    check(config_fields.valid_with_data, 1'b1);
    repeat (2) @(posedge clk);
    check({complete_pin_oe_n, complete_pin_out, valid_pin_oe_n, valid_pin_ready_level}, 4'h5);
    wr(a_cfg, 16'h4020);
    repeat (2) @(posedge clk);
    check({complete_pin_out, valid_pin_ready_level, config_fields.valid_with_data}, 3'b000);
    for (int k = 0; k < 5; k++)
    begin
      wr(a_cfg, {1'b0, 3'(k + 3), 3'(k), 9'h020});
      check({config_fields.burst_latency, config_fields.burst_length}, {3'(k + 3), 3'(k)});
    end
    wr(a_cfg, 16'h40C0);
    repeat (2) @(posedge clk);
    check({complete_pin_oe_n, valid_pin_oe_n}, 2'b11);
    wr(a_cfg, 16'h40E0);
    @(posedge clk);
    cold_reset <= 1'b1;
    @(posedge clk);
    cold_reset <= 1'b0;
    rd_chk(a_cfg, 32'h40C0);
  endtask : t_config
  task automatic t_commands;
    logic [15:0] codes [14];
    flash_cmd_pkg::op_type ops [14];
    int s;
    codes = '{16'h0000, 16'h0013, 16'h0080, 16'h001A, 16'h001B, 16'h0023, 16'h002A, 16'h002C,
      16'h0071, 16'h0094, 16'h0095, 16'h00B0, 16'h0030, 16'h0065};
    ops = '{flash_cmd_pkg::op_load, flash_cmd_pkg::op_load, flash_cmd_pkg::op_program,
      flash_cmd_pkg::op_program, flash_cmd_pkg::op_copy, flash_cmd_pkg::op_lock, flash_cmd_pkg::op_lock,
      flash_cmd_pkg::op_lock, flash_cmd_pkg::op_verify, flash_cmd_pkg::op_erase, flash_cmd_pkg::op_erase,
      flash_cmd_pkg::op_suspend, flash_cmd_pkg::op_resume, flash_cmd_pkg::op_otp};
    for (int i = 0; i < 14; i++)
    begin
      s = starts;
      run_cmd(codes[i]);
      check(starts - s, 1);
      check(last_req.op, ops[i]);
      check(array_command, codes[i]);
      if (i == 2 || i == 3) check({last_req.spare_only, last_req.both_areas}, (i == 2) ? 2'b01 : 2'b10);
    end
    rd_chk(a_stat, 32'h0000);
  endtask : t_commands
  task automatic t_fail_hot;
    fail_next <= 1'b1;
    run_cmd(16'h0013);
    fail_next <= 1'b0;
    rd_reg(a_stat);
    check(rd[10], 1'b1);
    wr(a_cfg, 16'hC3F0);
    wr(a_cmpl, 16'h0000);
    wr(a_cmd, 16'h00F3);
    repeat (4) @(posedge clk);
    rd_chk(a_cfg, 32'h40E0);
    rd_chk(a_stat, 32'h0000);
    wr(a_cmpl, 16'h0000);
    wr(a_cmd, 16'h0077);
    rd_reg(a_stat);
    check(rd[10], 1'b1);
  endtask : t_fail_hot
  task automatic t_busy;
    int s;
    delay <= 8'h28;
    wr(a_cmpl, 16'h0000);
    s = starts;
    wr(a_cmd, 16'h0094);
    wr(a_cmd, 16'h0023);
    rd_reg(a_stat);
    check({rd[15], rd[10]}, 2'b11);
    check(complete_pin_out, 1'b0);
    wr(a_cmd, 16'h00F0);
    wait_ready();
    check(starts - s, 2);
    check(last_req.op, flash_cmd_pkg::op_core_reset);
  endtask : t_busy
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial
  begin
    srst = 1'b1;
    cold_reset = 1'b0;
    fail_next = 1'b0;
    delay = 8'h03;
    s_axi_awaddr = 18'h00000;
    s_axi_araddr = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_commands();
    t_fail_hot();
    t_busy();
    stop_test();
  end
endmodule : tb_flash_command_and_sysconfig
